// [logic/distance_cfg_defines.svh]
// Register indices, field limits, reset values and range figures of the
// distance configuration register bank.
// Assumes inclusion by bare name from the bank module and the testbench.
`ifndef DISTANCE_CFG_DEFINES_SVH
`define DISTANCE_CFG_DEFINES_SVH

// ==========================================================================
// Register indices; the byte address on the bus is four times the index.
`define DCR_IDX_START     8'h20
`define DCR_IDX_SPAN      8'h21
`define DCR_IDX_GAIN      8'h24
`define DCR_IDX_POWER     8'h25
`define DCR_IDX_PROFILE   8'h28
`define DCR_IDX_DECIM     8'h29
`define DCR_IDX_AVG       8'h30
`define DCR_IDX_ATTEN     8'h32
`define DCR_IDX_ASYNC     8'h33
`define DCR_IDX_UNAMB     8'h34
`define DCR_IDX_STATUS    8'h35
`define DCR_IDX_META_ST   8'h81
`define DCR_IDX_META_SP   8'h82
`define DCR_IDX_META_CNT  8'h83

// ==========================================================================
// Field limits, codes and status bit positions.
`define DCR_GAIN_MAX      10'h3e8
`define DCR_PROFILE_MIN   3'h1
`define DCR_PROFILE_MAX   3'h5
`define DCR_UNAMB_SHORT   8'h06
`define DCR_UNAMB_LONG    8'h09
`define DCR_STAT_REJECT   0
`define DCR_STAT_HIBER    1

// ==========================================================================
// Range figures in millimetres for the two unambiguous-range codes.
`define DCR_UNAMB_SHORT_MM 32'h00002cec
`define DCR_MEAS_SHORT_MM  32'h00001b58
`define DCR_UNAMB_LONG_MM  32'h00004394
`define DCR_MEAS_LONG_MM   32'h0000319c

// ==========================================================================
// Reset values.
`define DCR_RST_START     32'h00000000
`define DCR_RST_SPAN      32'h00000000
`define DCR_RST_GAIN      10'h1f4
`define DCR_RST_PROFILE   3'h1
`define DCR_RST_DECIM     32'h00000001
`define DCR_RST_AVG       32'h00000001
`define DCR_RST_UNAMB     8'h06

`endif

// [logic/distance_cfg_pkg.sv]
// Types shared by the distance configuration register bank.
// Assumes the defines header is compiled alongside.
package distance_cfg_pkg;
  // ========================================================================
  // Sensor power states as coded in the power register.
  typedef enum logic [2:0] {
    PWR_OFF       = 3'h0,
    PWR_SLEEP     = 3'h1,
    PWR_READY     = 3'h2,
    PWR_ACTIVE    = 3'h3,
    PWR_HIBERNATE = 3'h4
  } power_state_t;
endpackage

// [logic/distance_config_register_bank.sv]
// Configuration register bank of the distance measurement service.
// Assumes a classic Wishbone master on clk_sys and a service that pulses
// service_create and data_produced with metadata valid in that cycle.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "distance_cfg_defines.svh"

// Function
// [R1] Writable registers hold the service configuration
// [R2] Metadata refreshes only on create or data
// [R3] Start register holds range start in mm
// [R4] Span register holds range length in mm
// [R5] Gain accepts zero through one thousand
// [R6] Power code zero off, three active
// [R7] Power code one sleep, two ready
// [R8] Host toggles pin for hibernate entry, exit
// [R9] Profile accepts codes one through five
// [R10] Decimation register holds sensor downsampling factor
// [R11] Averaging register sets hardware averaged samples
// [R12] Attenuation register enables maximum signal attenuation
// [R13] Async register switches asynchronous acquisition mode
// [R14] Code six: 11.5 m range, 7.0 m
// [R15] Code nine: 17.3 m range, 12.7 m
module distance_config_register_bank
  import distance_cfg_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        service_create,
  input  wire logic        data_produced,
  input  wire logic [31:0] meta_start_mm,
  input  wire logic [31:0] meta_span_mm,
  output logic      [31:0] cfg_start_mm,
  output logic      [31:0] cfg_span_mm,
  output logic      [9:0]  cfg_gain,
  output power_state_t     cfg_power,
  output logic             hibernate_sel,
  output logic      [2:0]  cfg_profile,
  output logic      [31:0] cfg_decimation,
  output logic      [31:0] cfg_averaging,
  output logic             cfg_attenuation,
  output logic             cfg_async,
  output logic      [7:0]  cfg_unamb_code,
  output logic      [31:0] cfg_unamb_mm,
  output logic      [31:0] cfg_max_dist_mm
);

  // ========================================================================
  // Bus decode.
  // Byte lanes merge into the old word; shared by every multi-bit writable register.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic [31:0] m_gain;
  logic [31:0] m_power;
  logic [31:0] m_prof;
  logic [31:0] m_unamb;
  logic        bad_gain;
  logic        bad_power;
  logic        bad_prof;
  logic        bad_unamb;
  logic        rejected;
  logic [31:0] meta_start;
  logic [31:0] meta_span;
  logic [31:0] meta_count;
  logic [31:0] read_value;

  // A request is taken once; the registered ack masks the repeat cycle.
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i;

  // Coded fields are checked on the merged word so partial writes are safe.
  assign m_gain    = merge({22'h0, cfg_gain}, wb_dat_i, wb_sel_i);
  assign m_power   = merge({29'h0, cfg_power}, wb_dat_i, wb_sel_i);
  assign m_prof    = merge({29'h0, cfg_profile}, wb_dat_i, wb_sel_i);
  assign m_unamb   = merge({24'h0, cfg_unamb_code}, wb_dat_i, wb_sel_i);
  assign bad_gain  = m_gain > {22'h0, `DCR_GAIN_MAX};
  assign bad_power = m_power > {29'h0, PWR_HIBERNATE};
  assign bad_prof  = (m_prof < {29'h0, `DCR_PROFILE_MIN})
                   | (m_prof > {29'h0, `DCR_PROFILE_MAX});
  assign bad_unamb = (m_unamb != {24'h0, `DCR_UNAMB_SHORT})
                   & (m_unamb != {24'h0, `DCR_UNAMB_LONG});

  // ========================================================================
  // Bus answer: one wait state, unmapped reads give zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data is registered with the ack and held until the next request.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_dat_o <= 32'h0;
    end else if (req) begin
      wb_dat_o <= wb_we_i ? 32'h0 : read_value;
    end
  end

  // ========================================================================
  // Plain range and sampling registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_start_mm   <= `DCR_RST_START;
      cfg_span_mm    <= `DCR_RST_SPAN;
      cfg_decimation <= `DCR_RST_DECIM;
      cfg_averaging  <= `DCR_RST_AVG;
    end else if (wr) begin
      if (idx == `DCR_IDX_START) begin
        cfg_start_mm <= merge(cfg_start_mm, wb_dat_i, wb_sel_i); // R1 R3
      end
      if (idx == `DCR_IDX_SPAN) begin
        cfg_span_mm <= merge(cfg_span_mm, wb_dat_i, wb_sel_i); // R4
      end
      if (idx == `DCR_IDX_DECIM) begin
        cfg_decimation <= merge(cfg_decimation, wb_dat_i, wb_sel_i); // R10
      end
      if (idx == `DCR_IDX_AVG) begin
        cfg_averaging <= merge(cfg_averaging, wb_dat_i, wb_sel_i); // R11
      end
    end
  end

  // ========================================================================
  // Single-bit switches sit in bit 0; upper bits read as zero.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_attenuation <= 1'b0;
      cfg_async       <= 1'b0;
    end else if (wr & wb_sel_i[0]) begin
      if (idx == `DCR_IDX_ATTEN) begin
        cfg_attenuation <= wb_dat_i[0]; // R12
      end
      if (idx == `DCR_IDX_ASYNC) begin
        cfg_async <= wb_dat_i[0]; // R13
      end
    end
  end

  // ========================================================================
  // Gain saturates at the top value so software never sees a wrap.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_gain <= `DCR_RST_GAIN;
    end else if (wr && idx == `DCR_IDX_GAIN) begin
      cfg_gain <= bad_gain ? `DCR_GAIN_MAX : m_gain[9:0]; // R5
    end
  end

  // ========================================================================
  // Power state: codes above hibernate are dropped, the old state stays.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_power <= PWR_ACTIVE;
    end else if (wr && idx == `DCR_IDX_POWER && !bad_power) begin
      cfg_power <= power_state_t'(m_power[2:0]); // R6 R7
    end
  end

  // The host must toggle its own pin in hibernate; this flag tells it so.
  assign hibernate_sel = (cfg_power == PWR_HIBERNATE); // R8

  // ========================================================================
  // Profile: codes outside one through five are dropped.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_profile <= `DCR_RST_PROFILE;
    end else if (wr && idx == `DCR_IDX_PROFILE && !bad_prof) begin
      cfg_profile <= m_prof[2:0]; // R9
    end
  end

  // ========================================================================
  // Unambiguous range; the distances are registered with the code so the
  // three outputs always change together.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_unamb_code  <= `DCR_RST_UNAMB;
      cfg_unamb_mm    <= `DCR_UNAMB_SHORT_MM;
      cfg_max_dist_mm <= `DCR_MEAS_SHORT_MM;
    end else if (wr && idx == `DCR_IDX_UNAMB && !bad_unamb) begin
      cfg_unamb_code <= m_unamb[7:0];
      if (m_unamb[7:0] == `DCR_UNAMB_LONG) begin
        cfg_unamb_mm    <= `DCR_UNAMB_LONG_MM; // R15
        cfg_max_dist_mm <= `DCR_MEAS_LONG_MM; // R15
      end else begin
        cfg_unamb_mm    <= `DCR_UNAMB_SHORT_MM; // R14
        cfg_max_dist_mm <= `DCR_MEAS_SHORT_MM; // R14
      end
    end
  end

  // ========================================================================
  // Sticky reject flag; a new reject in the clearing cycle wins.
  logic set_reject;
  logic clr_reject;
  assign set_reject = wr & (((idx == `DCR_IDX_GAIN) & bad_gain)
                    | ((idx == `DCR_IDX_POWER) & bad_power)
                    | ((idx == `DCR_IDX_PROFILE) & bad_prof)
                    | ((idx == `DCR_IDX_UNAMB) & bad_unamb));
  assign clr_reject = wr & (idx == `DCR_IDX_STATUS) & wb_sel_i[0]
                    & wb_dat_i[`DCR_STAT_REJECT];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rejected <= 1'b0;
    end else begin
      rejected <= set_reject | (rejected & ~clr_reject);
    end
  end

  // ========================================================================
  // Read-only metadata changes only on create or on produced data.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_start <= 32'h0;
      meta_span  <= 32'h0;
      meta_count <= 32'h0;
    end else if (service_create | data_produced) begin
      meta_start <= meta_start_mm; // R2
      meta_span  <= meta_span_mm; // R2
      meta_count <= meta_count + 32'h1;
    end
  end

  // ========================================================================
  // Read multiplexer.
  always_comb begin
    read_value = 32'h0;
    case (idx)
      `DCR_IDX_START:    read_value = cfg_start_mm;
      `DCR_IDX_SPAN:     read_value = cfg_span_mm;
      `DCR_IDX_GAIN:     read_value = {22'h0, cfg_gain};
      `DCR_IDX_POWER:    read_value = {29'h0, cfg_power};
      `DCR_IDX_PROFILE:  read_value = {29'h0, cfg_profile};
      `DCR_IDX_DECIM:    read_value = cfg_decimation;
      `DCR_IDX_AVG:      read_value = cfg_averaging;
      `DCR_IDX_ATTEN:    read_value = {31'h0, cfg_attenuation};
      `DCR_IDX_ASYNC:    read_value = {31'h0, cfg_async};
      `DCR_IDX_UNAMB:    read_value = {24'h0, cfg_unamb_code};
      `DCR_IDX_STATUS:   read_value = {30'h0, hibernate_sel, rejected};
      `DCR_IDX_META_ST:  read_value = meta_start;
      `DCR_IDX_META_SP:  read_value = meta_span;
      `DCR_IDX_META_CNT: read_value = meta_count;
      default:           read_value = 32'h0;
    endcase
  end

  // ========================================================================
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_wr(logic [7:0] i);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && idx == i;
  endsequence

  property p_ack_once;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not single");

  property p_start_wr;
    s_wr(`DCR_IDX_START) ##0 wb_sel_i == 4'hf
      |=> cfg_start_mm == $past(wb_dat_i);
  endproperty
  a_start_wr: assert property (p_start_wr) else $error("start lost"); // R3

  property p_gain_sat;
    s_wr(`DCR_IDX_GAIN) ##0 wb_sel_i == 4'hf ##0 wb_dat_i > 32'h3e8
      |=> cfg_gain == `DCR_GAIN_MAX && rejected;
  endproperty
  a_gain_sat: assert property (p_gain_sat) else $error("gain not clamped"); // R5

  property p_gain_range;
    cfg_gain <= `DCR_GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain over top"); // R5

  property p_power_bad;
    s_wr(`DCR_IDX_POWER) ##0 bad_power |=> $stable(cfg_power);
  endproperty
  a_power_bad: assert property (p_power_bad) else $error("bad power taken"); // R6

  property p_profile_range;
    cfg_profile >= `DCR_PROFILE_MIN && cfg_profile <= `DCR_PROFILE_MAX;
  endproperty
  a_profile_range: assert property (p_profile_range) else $error("bad profile"); // R9

  property p_unamb_short;
    cfg_unamb_code == `DCR_UNAMB_SHORT
      |-> cfg_unamb_mm == 32'h2cec && cfg_max_dist_mm == 32'h1b58;
  endproperty
  a_unamb_short: assert property (p_unamb_short) else $error("code 6 range"); // R14

  property p_unamb_long;
    cfg_unamb_code == `DCR_UNAMB_LONG
      |-> cfg_unamb_mm == 32'h4394 && cfg_max_dist_mm == 32'h319c;
  endproperty
  a_unamb_long: assert property (p_unamb_long) else $error("code 9 range"); // R15

  property p_meta_hold;
    !(service_create || data_produced) |=> $stable(meta_start) && $stable(meta_span) && $stable(meta_count);
  endproperty
  a_meta_hold: assert property (p_meta_hold) else $error("meta moved"); // R2

  // Metadata is taken from the service on a create or data event.
  property p_meta_load;
    (service_create || data_produced)
      |=> meta_start == $past(meta_start_mm) && meta_span == $past(meta_span_mm);
  endproperty
  a_meta_load: assert property (p_meta_load) else $error("meta not loaded"); // R2

  // Full-word writes land unchanged in the plain registers.
  property p_span_wr;
    s_wr(`DCR_IDX_SPAN) ##0 wb_sel_i == 4'hf
      |=> cfg_span_mm == $past(wb_dat_i);
  endproperty
  a_span_wr: assert property (p_span_wr) else $error("span lost"); // R4

  property p_decim_wr;
    s_wr(`DCR_IDX_DECIM) ##0 wb_sel_i == 4'hf
      |=> cfg_decimation == $past(wb_dat_i);
  endproperty
  a_decim_wr: assert property (p_decim_wr) else $error("decimation lost"); // R10

  property p_avg_wr;
    s_wr(`DCR_IDX_AVG) ##0 wb_sel_i == 4'hf
      |=> cfg_averaging == $past(wb_dat_i);
  endproperty
  a_avg_wr: assert property (p_avg_wr) else $error("averaging lost"); // R11

  // The switches follow bit 0 whenever its byte lane is enabled.
  property p_atten_wr;
    s_wr(`DCR_IDX_ATTEN) ##0 wb_sel_i[0]
      |=> cfg_attenuation == $past(wb_dat_i[0]);
  endproperty
  a_atten_wr: assert property (p_atten_wr) else $error("attenuation lost"); // R12

  property p_async_wr;
    s_wr(`DCR_IDX_ASYNC) ##0 wb_sel_i[0]
      |=> cfg_async == $past(wb_dat_i[0]);
  endproperty
  a_async_wr: assert property (p_async_wr) else $error("async lost"); // R13

  // A legal power code is stored exactly as written.
  property p_power_ok;
    s_wr(`DCR_IDX_POWER) ##0 !bad_power
      |=> cfg_power == $past(m_power[2:0]);
  endproperty
  a_power_ok: assert property (p_power_ok) else $error("power code lost"); // R7

  // Read data carries the register value seen when the request was taken.
  property p_read_start;
    (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && idx == `DCR_IDX_START)
      |=> wb_ack_o && wb_dat_o == $past(cfg_start_mm);
  endproperty
  a_read_start: assert property (p_read_start) else $error("start read wrong"); // R1

endmodule

// [testbench/distance_config_register_bank_tb.sv]
// Self-checking bench for the distance configuration register bank.
// Assumes the bank, its package and its defines header are compiled first.
`timescale 1ns/1ps
`include "distance_cfg_defines.svh"

module distance_config_register_bank_tb
  import distance_cfg_pkg::*;
;
  // ==========================================================================
  // Stimulus, observed outputs and bookkeeping.
  typedef struct packed {
    logic [7:0]  idx;
    logic [31:0] wd;
    logic [3:0]  sel;
    logic [31:0] exp;
  } row_t;

  logic         clk_sys        = 1'b0;
  logic         rst            = 1'b1;
  logic         wb_cyc_i       = 1'b0;
  logic         wb_stb_i       = 1'b0;
  logic         wb_we_i        = 1'b0;
  logic [9:0]   wb_adr_i       = 10'h000;
  logic [3:0]   wb_sel_i       = 4'h0;
  logic [31:0]  wb_dat_i       = 32'h00000000;
  logic         service_create = 1'b0;
  logic         data_produced  = 1'b0;
  logic [31:0]  meta_start_mm  = 32'h00000000;
  logic [31:0]  meta_span_mm   = 32'h00000000;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  logic [31:0]  cfg_start_mm;
  logic [31:0]  cfg_span_mm;
  logic [9:0]   cfg_gain;
  power_state_t cfg_power;
  logic         hibernate_sel;
  logic [2:0]   cfg_profile;
  logic [31:0]  cfg_decimation;
  logic [31:0]  cfg_averaging;
  logic         cfg_attenuation;
  logic         cfg_async;
  logic [7:0]   cfg_unamb_code;
  logic [31:0]  cfg_unamb_mm;
  logic [31:0]  cfg_max_dist_mm;
  int           errors         = 0;
  int           n_tests        = 0;

  // Rows with a zero byte enable are only read, so they check reset values.
  row_t rows [32] = '{
    '{8'h20, 32'h0, 4'h0, 32'h0}, '{8'h21, 32'h0, 4'h0, 32'h0}, '{8'h24, 32'h0, 4'h0, 32'h1f4},
    '{8'h25, 32'h0, 4'h0, 32'h3}, '{8'h28, 32'h0, 4'h0, 32'h1}, '{8'h29, 32'h0, 4'h0, 32'h1},
    '{8'h30, 32'h0, 4'h0, 32'h1}, '{8'h32, 32'h0, 4'h0, 32'h0}, '{8'h33, 32'h0, 4'h0, 32'h0},
    '{8'h34, 32'h0, 4'h0, 32'h6},
    '{8'h20, 32'h12345678, 4'hf, 32'h12345678}, '{8'h21, 32'hfa0, 4'hf, 32'hfa0},
    '{8'h24, 32'h0, 4'hf, 32'h0}, '{8'h24, 32'h3e8, 4'hf, 32'h3e8}, '{8'h24, 32'h3e9, 4'hf, 32'h3e8},
    '{8'h25, 32'h0, 4'hf, 32'h0}, '{8'h25, 32'h1, 4'hf, 32'h1}, '{8'h25, 32'h2, 4'hf, 32'h2},
    '{8'h25, 32'h4, 4'hf, 32'h4}, '{8'h25, 32'h3, 4'hf, 32'h3},
    '{8'h28, 32'h1, 4'hf, 32'h1}, '{8'h28, 32'h2, 4'hf, 32'h2}, '{8'h28, 32'h3, 4'hf, 32'h3},
    '{8'h28, 32'h4, 4'hf, 32'h4}, '{8'h28, 32'h5, 4'hf, 32'h5},
    '{8'h29, 32'h4, 4'hf, 32'h4}, '{8'h30, 32'h8, 4'hf, 32'h8}, '{8'h32, 32'h1, 4'hf, 32'h1},
    '{8'h32, 32'h0, 4'hf, 32'h0}, '{8'h33, 32'h1, 4'hf, 32'h1}, '{8'h34, 32'h6, 4'hf, 32'h6},
    '{8'h34, 32'h9, 4'hf, 32'h9}
  };

  // ==========================================================================
  // Clock, device under test and watchdog.
  always #2 clk_sys = ~clk_sys;

  distance_config_register_bank distance_config_register_bank_inst (
    .clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .service_create, .data_produced, .meta_start_mm, .meta_span_mm,
    .cfg_start_mm, .cfg_span_mm, .cfg_gain, .cfg_power, .hibernate_sel, .cfg_profile,
    .cfg_decimation, .cfg_averaging, .cfg_attenuation, .cfg_async, .cfg_unamb_code,
    .cfg_unamb_mm, .cfg_max_dist_mm
  );

  // The whole run needs well under a thousand bus cycles; this cuts a hang.
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    results();
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [31:0] d,
                         input logic [3:0] s, output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      $display("Error at %0t: ack %h expected %h", $time, wb_ack_o, 1'b1);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    wb_xfer(1'b1, idx, d, s, rd);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, idx, 32'h0, 4'hf, rd);
    chk(rd, exp);
  endtask

  // A one-cycle metadata strobe, either the create or the data event.
  task automatic pulse_meta(input logic dp, input logic [31:0] st, input logic [31:0] sp);
    @(posedge clk_sys);
    service_create <= !dp;
    data_produced  <= dp;
    meta_start_mm  <= st;
    meta_span_mm   <= sp;
    @(posedge clk_sys);
    service_create <= 1'b0;
    data_produced  <= 1'b0;
  endtask

  // The configuration output that mirrors a writable register.
  function automatic logic [31:0] port_of(input logic [7:0] idx);
    case (idx)
      8'h20:   return cfg_start_mm;
      8'h21:   return cfg_span_mm;
      8'h24:   return {22'h0, cfg_gain};
      8'h25:   return {29'h0, cfg_power};
      8'h28:   return {29'h0, cfg_profile};
      8'h29:   return cfg_decimation;
      8'h30:   return cfg_averaging;
      8'h32:   return {31'h0, cfg_attenuation};
      8'h33:   return {31'h0, cfg_async};
      8'h34:   return {24'h0, cfg_unamb_code};
      default: return 32'hxxxxxxxx;
    endcase
  endfunction

  task automatic results();
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence: table first, then the awkward cases.
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(`DCR_IDX_STATUS, 32'h0);
    for (int i = 0; i < 32; i++) begin
      if (rows[i].sel != 4'h0) wr(rows[i].idx, rows[i].wd, rows[i].sel);
      rdchk(rows[i].idx, rows[i].exp);
      chk(port_of(rows[i].idx), rows[i].exp);
    end
    chk(cfg_unamb_mm, `DCR_UNAMB_LONG_MM);
    chk(cfg_max_dist_mm, `DCR_MEAS_LONG_MM);
    wr(`DCR_IDX_UNAMB, 32'h6, 4'hf);
    chk(cfg_unamb_mm, `DCR_UNAMB_SHORT_MM);
    chk(cfg_max_dist_mm, `DCR_MEAS_SHORT_MM);
    // Refused codes leave the field alone and raise the sticky flag.
    wr(`DCR_IDX_STATUS, 32'h1, 4'hf);
    wr(`DCR_IDX_POWER, 32'h4, 4'hf);
    chk({31'h0, hibernate_sel}, 32'h1);
    rdchk(`DCR_IDX_STATUS, 32'h2);
    wr(`DCR_IDX_POWER, 32'h5, 4'hf);
    rdchk(`DCR_IDX_POWER, 32'h4);
    rdchk(`DCR_IDX_STATUS, 32'h3);
    wr(`DCR_IDX_PROFILE, 32'h0, 4'hf);
    wr(`DCR_IDX_PROFILE, 32'h6, 4'hf);
    rdchk(`DCR_IDX_PROFILE, 32'h5);
    wr(`DCR_IDX_UNAMB, 32'h7, 4'hf);
    rdchk(`DCR_IDX_UNAMB, 32'h6);
    wr(`DCR_IDX_STATUS, 32'h1, 4'hf);
    rdchk(`DCR_IDX_STATUS, 32'h2);
    wr(`DCR_IDX_POWER, 32'h3, 4'hf);
    chk({31'h0, hibernate_sel}, 32'h0);
    // Byte enables merge into the held value.
    wr(`DCR_IDX_START, 32'hffffffff, 4'hf);
    wr(`DCR_IDX_START, 32'h0, 4'h2);
    rdchk(`DCR_IDX_START, 32'hffff00ff);
    chk(cfg_start_mm, 32'hffff00ff);
    // Unmapped and read-only places ignore writes.
    wr(8'h22, 32'h5a5a5a5a, 4'hf);
    rdchk(8'h22, 32'h0);
    wr(`DCR_IDX_META_ST, 32'h5a5a5a5a, 4'hf);
    rdchk(`DCR_IDX_META_ST, 32'h0);
    // Metadata moves only on a create or data event.
    pulse_meta(1'b0, 32'h111, 32'h222);
    rdchk(`DCR_IDX_META_ST, 32'h111);
    rdchk(`DCR_IDX_META_SP, 32'h222);
    rdchk(`DCR_IDX_META_CNT, 32'h1);
    @(posedge clk_sys);
    meta_start_mm <= 32'h333;
    repeat (3) @(posedge clk_sys);
    rdchk(`DCR_IDX_META_ST, 32'h111);
    pulse_meta(1'b1, 32'h444, 32'h555);
    rdchk(`DCR_IDX_META_ST, 32'h444);
    rdchk(`DCR_IDX_META_CNT, 32'h2);
    // A second reset in mid-run restores the defaults.
    wr(`DCR_IDX_GAIN, 32'h7, 4'hf);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({22'h0, cfg_gain}, 32'h1f4);
    chk({29'h0, cfg_power}, 32'h3);
    rdchk(`DCR_IDX_META_CNT, 32'h0);
    results();
  end
endmodule
